// ==== uefc_regs.vh ====
// offsets, fields and limits of the frame fifo control block
`ifndef UEFC_REGS_VH
`define UEFC_REGS_VH
// apb register byte addresses
`define UEFC_CTRL_ADDR      12'h000
`define UEFC_STAT_ADDR      12'h004
`define UEFC_RXSTAT_ADDR    12'h008
`define UEFC_TXCMDB_ADDR    12'h00C
// control register fields
`define UEFC_CTRL_RX_PATH_ENABLE      0
`define UEFC_CTRL_FLUSH     1
`define UEFC_CTRL_PASSBAD   2
`define UEFC_CTRL_SUMON     3
`define UEFC_CTRL_RESET     32'h00000000
// status register fields
`define UEFC_STAT_TXERR     0
`define UEFC_STAT_HALTED    1
`define UEFC_STAT_SUMRUN    2
`define UEFC_STAT_RXFRAME   3
// receive status word fields
`define UEFC_RS_FILTFAIL    30
`define UEFC_RS_LEN_HI      29
`define UEFC_RS_LEN_LO      16
`define UEFC_RS_ES          15
`define UEFC_RS_BCAST       13
`define UEFC_RS_LENERR      12
`define UEFC_RS_RUNT        11
`define UEFC_RS_MCAST       10
`define UEFC_RS_TOOLONG     7
`define UEFC_RS_LATECOL     6
`define UEFC_RS_ETHTYPE     5
`define UEFC_RS_WDOG        4
`define UEFC_RS_MIIERR      3
`define UEFC_RS_DRIBBLE     2
`define UEFC_RS_CRCERR      1
// frame size limits in bytes
`define UEFC_RUNT_BYTES     14'd64
`define UEFC_MAXLEN_BYTES   14'd1518
`define UEFC_ETHTYPE_MIN    16'd1500
`define UEFC_HDR_BYTES      14'd14
`define UEFC_WDOG_BYTES     14'd2048
// transmit command fields
`define UEFC_CA_OFS_HI      17
`define UEFC_CA_OFS_LO      16
`define UEFC_CA_FIRST       13
`define UEFC_CA_LAST        12
`define UEFC_CB_SUM         14
`define UEFC_CB_NOCRC       13
`define UEFC_CB_NOPAD       12
`define UEFC_SIZE_HI        10
// fifo depths (address bits)
`define UEFC_RXAW           4
`define UEFC_TXAW           4
`endif

// ==== uefc_fifo_ctrl.v ====
// frame fifo control between usb packet units and the ethernet mac side
// Notes on behaviour
// RL1: bit 13 broadcast, bit 10 multicast
// RL2: bit 12 flags length field mismatch
// RL3: bit 11 runt; pass only if allowed
// RL4: bit 7 over 1518 bytes, no truncation
// RL5: bit 6 marks late collision
// RL6: bit 5 type field above 1500
// RL7: bit 4 receive watchdog expiry
// RL8: bit 3 receive error seen in frame
// RL9: bit 2 dribble, never with bit 6
// RL10: bit 1 crc error or receive error
// RL11: flush resets pointers, self clears
// RL12: software stops receiver before flushing
// RL13: enable clear halts, pulse, re-enable resumes
// RL14: tx write side stores, rewinds errored packets
// RL15: each buffer opens with words A, B
// RL16: word B copies must match except sum
// RL17: word A offset, first, last, size
// RL18: sizes summed and compared with length
// RL19: sum only with request, first, offload
// RL20: B13 no crc, B12 no pad
// RL21: length sizes transfer, last byte enables
// RL22: payload third word, offset selects byte
// RL23: bit 15 ors runt, long, late, crc
// RL24: bits 29:16 size, bit 30 filter fail
// RL25: error flag sticks until reset
//
// The register addresses and the APB register port were chosen for this implementation.
`include "uefc_regs.vh"
`default_nettype none

module uefc_fifo_ctrl (
	// clock and reset
	input  wire        pclk,
	input  wire        presetn,
	// apb slave
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [11:0] paddr,
	input  wire [31:0] pwdata,
	output reg  [31:0] prdata,
	output wire        pready,
	output wire        pslverr,
	// mac receive side, one byte per cycle
	input  wire        rx_valid,
	input  wire [7:0]  rx_byte,
	input  wire        rx_end,
	input  wire        rx_crc_bad,
	input  wire        rx_media_err,
	input  wire        rx_late_col,
	input  wire [2:0]  rx_dribble_bits,
	input  wire        rx_slow_mode,
	input  wire        rx_filter_fail,
	output reg         rx_halted_pulse,
	output wire        rx_frame_accept,
	output reg  [31:0] rx_status_word,
	output reg         rx_status_valid,
	// usb bulk-out write side
	input  wire        out_valid,
	input  wire [31:0] out_word,
	input  wire        out_commit,
	input  wire        out_rewind,
	output wire        out_ready,
	// mac transmit side
	output reg         tx_valid,
	output reg  [31:0] tx_data,
	output reg  [3:0]  tx_byte_en,
	output reg         tx_last,
	output reg         tx_no_crc,
	output reg         tx_no_pad,
	output reg         tx_sum_start,
	input  wire        tx_ready,
	output reg         tx_sync_error_flag
);

	// state of the transmit extractor
	localparam [1:0] ST_CMDA = 2'd0;
	localparam [1:0] ST_CMDB = 2'd1;
	localparam [1:0] ST_DATA = 2'd2;
	localparam [1:0] ST_HALT = 2'd3;

	// synchronised receive pins
	reg [1:0]  s_valid;
	reg [1:0]  s_end;
	reg [1:0]  s_err;
	reg [7:0]  s_byte_a;            // first stage only
	reg [7:0]  s_byte;
	// control register bits
	reg        rx_path_enable;
	reg        rx_flush;
	reg        pass_bad;
	reg        sum_offload_on;
	// receive frame tracking
	reg [13:0] rx_count;
	reg [15:0] rx_lentype;
	reg [47:0] rx_dest;
	reg        rx_err_seen;
	reg        rx_active;
	reg        rx_was_enabled;
	reg [`UEFC_RXAW-1:0] rx_wr_ptr;
	reg [`UEFC_RXAW-1:0] rx_head_ptr;
	// transmit fifo storage and pointers
	reg [31:0] tx_mem [0:(1<<`UEFC_TXAW)-1];
	reg [`UEFC_TXAW:0] tx_wr_ptr;
	reg [`UEFC_TXAW:0] tx_head_ptr;
	reg [`UEFC_TXAW:0] tx_rd_ptr;
	// transmit extractor state
	reg [1:0]  tx_state;
	reg [31:0] cmd_a;
	reg [31:0] cmd_b_ref;
	reg        in_frame;
	reg [10:0] frame_sum;
	reg [10:0] buf_left;
	reg [10:0] frame_left;
	reg [1:0]  cur_ofs;
	reg        first_word;
	reg        sum_running;

	// apb decode
	wire wr_en = psel & penable & pwrite;
	wire mapped = (paddr == `UEFC_CTRL_ADDR) | (paddr == `UEFC_STAT_ADDR) |
		(paddr == `UEFC_RXSTAT_ADDR) | (paddr == `UEFC_TXCMDB_ADDR);
	assign pready  = 1'b1;
	assign pslverr = psel & penable & ~mapped;

	// fifo levels
	wire [`UEFC_TXAW:0] tx_used = tx_wr_ptr - tx_rd_ptr;
	wire tx_full  = tx_used[`UEFC_TXAW];
	wire tx_avail = (tx_head_ptr != tx_rd_ptr);
	assign out_ready = ~tx_full;

	// byte enables from offset and remaining count
	function [3:0] uefc_lanes;
		input [1:0]  ofs;
		input [10:0] left;
		reg   [2:0]  room;
		reg   [2:0]  take;
		begin
			room = 3'd4 - {1'b0, ofs};
			take = (left < {8'd0, room}) ? left[2:0] : room;
			uefc_lanes = ((4'hF >> (3'd4 - take)) << ofs);
		end
	endfunction

	// number of set lanes
	function [2:0] uefc_cnt;
		input [3:0] be;
		begin
			uefc_cnt = {2'b00, be[0]} + {2'b00, be[1]} + {2'b00, be[2]} + {2'b00, be[3]};
		end
	endfunction

	// synchronise receive pins, bytes only read after the second stage
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_valid  <= 2'b00;
			s_end    <= 2'b00;
			s_err    <= 2'b00;
			s_byte_a <= 8'h00;
			s_byte   <= 8'h00;
		end else begin
			s_valid  <= {s_valid[0], rx_valid};
			s_end    <= {s_end[0], rx_end};
			s_err    <= {s_err[0], rx_media_err};
			s_byte_a <= rx_byte;
			s_byte   <= s_byte_a;
		end
	end

	// register writes; flush self clears after one cycle, on the edge that resets the pointers
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rx_path_enable <= 1'b0;
			rx_flush       <= 1'b0;
			pass_bad       <= 1'b0;
			sum_offload_on <= 1'b0;
		end else begin
			if (rx_flush)
				rx_flush <= 1'b0; // see RL11
			if (wr_en && paddr == `UEFC_CTRL_ADDR) begin
				rx_path_enable <= pwdata[`UEFC_CTRL_RX_PATH_ENABLE]; // see RL13
				pass_bad       <= pwdata[`UEFC_CTRL_PASSBAD];
				sum_offload_on <= pwdata[`UEFC_CTRL_SUMON];
				if (pwdata[`UEFC_CTRL_FLUSH])
					rx_flush <= 1'b1;
			end
		end
	end

	// read mux
	always @* begin
		case (paddr)
			`UEFC_CTRL_ADDR:   prdata = {28'h0000000, sum_offload_on, pass_bad,
				rx_flush, rx_path_enable};
			`UEFC_STAT_ADDR:   prdata = {28'h0000000, rx_active, sum_running,
				~rx_path_enable & ~rx_active, tx_sync_error_flag};
			`UEFC_RXSTAT_ADDR: prdata = rx_status_word;
			`UEFC_TXCMDB_ADDR: prdata = cmd_b_ref;
			default:           prdata = 32'h00000000;
		endcase
	end

	// receive path: collect header, count bytes, build status word
	wire rx_take = s_valid[1] & rx_active;
	wire [13:0] fin_len = rx_count;
	wire is_runt  = fin_len < `UEFC_RUNT_BYTES;
	wire is_long  = fin_len > `UEFC_MAXLEN_BYTES;
	wire is_wdog  = fin_len > `UEFC_WDOG_BYTES;
	wire is_ety   = (fin_len >= `UEFC_HDR_BYTES) && (rx_lentype > `UEFC_ETHTYPE_MIN);
	wire len_bad  = (fin_len >= `UEFC_HDR_BYTES) && (rx_lentype <= `UEFC_ETHTYPE_MIN) &&
		(rx_lentype[13:0] != fin_len - `UEFC_HDR_BYTES);
	wire drib_hit = rx_slow_mode ? (rx_dribble_bits >= 3'd3) : (rx_dribble_bits == 3'd4);
	wire crc_flag = rx_crc_bad | rx_err_seen | s_err[1];
	assign rx_frame_accept = rx_status_valid & (~rx_status_word[`UEFC_RS_RUNT] | pass_bad); // see RL3

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rx_count        <= 14'd0;
			rx_lentype      <= 16'h0000;
			rx_dest         <= 48'h000000000000;
			rx_err_seen     <= 1'b0;
			rx_active       <= 1'b0;
			rx_was_enabled  <= 1'b0;
			rx_halted_pulse <= 1'b0;
			rx_status_word  <= 32'h00000000;
			rx_status_valid <= 1'b0;
			rx_wr_ptr       <= {`UEFC_RXAW{1'b0}};
			rx_head_ptr     <= {`UEFC_RXAW{1'b0}};
		end else begin
			rx_status_valid <= 1'b0;
			rx_halted_pulse <= 1'b0;
			// stop takes effect between frames, then one halted pulse
			rx_was_enabled <= rx_path_enable | rx_active;
			if (rx_was_enabled && !rx_path_enable && !rx_active)
				rx_halted_pulse <= 1'b1; // see RL13
			if (!rx_active && rx_path_enable && s_valid[1] && !s_end[1]) begin
				rx_active   <= 1'b1;
				rx_count    <= 14'd1;
				rx_dest     <= {40'h0000000000, s_byte};
				rx_err_seen <= s_err[1];
			end else if (rx_take) begin
				if (s_err[1])
					rx_err_seen <= 1'b1; // see RL8
				if (rx_count < 14'd6)
					rx_dest <= {rx_dest[39:0], s_byte};
				if (rx_count == 14'd12)
					rx_lentype[15:8] <= s_byte;
				if (rx_count == 14'd13)
					rx_lentype[7:0] <= s_byte;
				// counting continues past the maximum length
				rx_count <= rx_count + 14'd1; // see RL4
				rx_wr_ptr <= rx_wr_ptr + {{(`UEFC_RXAW-1){1'b0}}, 1'b1};
			end
			if (rx_active && s_end[1]) begin
				rx_active <= 1'b0;
				rx_status_valid <= 1'b1;
				rx_head_ptr <= rx_wr_ptr;
				rx_status_word <= 32'h00000000;
				rx_status_word[`UEFC_RS_FILTFAIL] <= rx_filter_fail; // see RL24
				rx_status_word[`UEFC_RS_LEN_HI:`UEFC_RS_LEN_LO] <= fin_len; // see RL24
				rx_status_word[`UEFC_RS_ES] <= is_runt | is_long | rx_late_col |
					(crc_flag & ~is_runt & ~rx_late_col & ~is_wdog); // see RL23
				rx_status_word[`UEFC_RS_BCAST] <= &rx_dest; // see RL1
				rx_status_word[`UEFC_RS_MCAST] <= rx_dest[40] & ~(&rx_dest); // see RL1
				rx_status_word[`UEFC_RS_LENERR] <= len_bad; // see RL2
				rx_status_word[`UEFC_RS_RUNT] <= is_runt; // see RL3
				rx_status_word[`UEFC_RS_TOOLONG] <= is_long; // see RL4
				rx_status_word[`UEFC_RS_LATECOL] <= rx_late_col; // see RL5
				rx_status_word[`UEFC_RS_ETHTYPE] <= is_ety; // see RL6
				rx_status_word[`UEFC_RS_WDOG] <= is_wdog; // see RL7
				rx_status_word[`UEFC_RS_MIIERR] <= rx_err_seen | s_err[1]; // see RL8
				rx_status_word[`UEFC_RS_DRIBBLE] <= drib_hit & ~rx_late_col; // see RL9
				rx_status_word[`UEFC_RS_CRCERR] <= crc_flag & ~is_runt &
					~rx_late_col & ~is_wdog; // see RL10
			end
			// flush returns both pointers to reset; receiver already stopped
			if (rx_flush) begin
				rx_wr_ptr <= {`UEFC_RXAW{1'b0}}; // see RL11
				rx_head_ptr <= {`UEFC_RXAW{1'b0}}; // see RL11
			end
		end
	end

	// bulk-out write side, raw words with head pointer for rewind
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tx_wr_ptr   <= {(`UEFC_TXAW+1){1'b0}};
			tx_head_ptr <= {(`UEFC_TXAW+1){1'b0}};
		end else begin
			if (out_rewind)
				tx_wr_ptr <= tx_head_ptr; // see RL14
			else if (out_valid && !tx_full)
				tx_wr_ptr <= tx_wr_ptr + {{`UEFC_TXAW{1'b0}}, 1'b1};
			if (out_commit && !out_rewind)
				tx_head_ptr <= tx_wr_ptr + {{`UEFC_TXAW{1'b0}}, (out_valid & ~tx_full)};
		end
	end

	// storage written without processing
	always @(posedge pclk) begin
		if (out_valid && !tx_full && !out_rewind)
			tx_mem[tx_wr_ptr[`UEFC_TXAW-1:0]] <= out_word;  // see RL14
	end

	// read side: command A, command B, then payload words
	wire [31:0] rd_word = tx_mem[tx_rd_ptr[`UEFC_TXAW-1:0]];
	wire [10:0] a_size  = rd_word[`UEFC_SIZE_HI:0];
	wire [10:0] b_len   = rd_word[`UEFC_SIZE_HI:0];
	wire [10:0] new_sum = frame_sum + cmd_a[`UEFC_SIZE_HI:0];
	wire        can_out = ~tx_valid | tx_ready;
	wire [3:0]  lanes   = uefc_lanes(first_word ? cur_ofs : 2'b00, buf_left);
	wire [10:0] lane_n  = {8'd0, uefc_cnt(lanes)};
	wire        b_differs = ({rd_word[31:15], rd_word[13:0]} !=
		{cmd_b_ref[31:15], cmd_b_ref[13:0]});
	// error checks on commands A and B against frame so far
	wire b_bad = in_frame ? (b_differs | cmd_a[`UEFC_CA_FIRST]) :
		~cmd_a[`UEFC_CA_FIRST];
	wire a_bad = (new_sum < b_len) ? cmd_a[`UEFC_CA_LAST] : ~cmd_a[`UEFC_CA_LAST];
	wire sz_bad = (cmd_a[`UEFC_SIZE_HI:0] == 11'd0) | (cmd_a[`UEFC_CA_LAST] & (new_sum != b_len));

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tx_state    <= ST_CMDA;
			tx_rd_ptr   <= {(`UEFC_TXAW+1){1'b0}};
			cmd_a       <= 32'h00000000;
			cmd_b_ref   <= 32'h00000000;
			in_frame    <= 1'b0;
			frame_sum   <= 11'd0;
			buf_left    <= 11'd0;
			frame_left  <= 11'd0;
			cur_ofs     <= 2'b00;
			first_word  <= 1'b0;
			sum_running <= 1'b0;
			tx_valid    <= 1'b0;
			tx_data     <= 32'h00000000;
			tx_byte_en  <= 4'h0;
			tx_last     <= 1'b0;
			tx_no_crc   <= 1'b0;
			tx_no_pad   <= 1'b0;
			tx_sum_start <= 1'b0;
			tx_sync_error_flag <= 1'b0;
		end else begin
			tx_sum_start <= 1'b0;
			if (tx_valid && tx_ready)
				tx_valid <= 1'b0;
			case (tx_state)
				// first command word of a buffer
				ST_CMDA: begin
					if (tx_avail) begin
						cmd_a     <= rd_word; // see RL15
						cur_ofs   <= rd_word[`UEFC_CA_OFS_HI:`UEFC_CA_OFS_LO]; // see RL17
						buf_left  <= a_size; // see RL17
						tx_rd_ptr <= tx_rd_ptr + {{`UEFC_TXAW{1'b0}}, 1'b1};
						tx_state  <= ST_CMDB;
					end
				end
				// second command word, checked against the frame
				ST_CMDB: begin
					if (tx_avail) begin
						tx_rd_ptr  <= tx_rd_ptr + {{`UEFC_TXAW{1'b0}}, 1'b1};
						first_word <= 1'b1; // see RL22
						if (b_bad | a_bad | sz_bad) begin
							tx_sync_error_flag <= 1'b1; // see RL16 RL18
							tx_state <= ST_HALT;
						end else begin
							tx_state  <= ST_DATA;
							frame_sum <= cmd_a[`UEFC_CA_LAST] ? 11'd0 : new_sum; // see RL18
							in_frame  <= ~cmd_a[`UEFC_CA_LAST];
							if (!in_frame) begin
								cmd_b_ref  <= rd_word;
								frame_left <= b_len;           // see RL21
								tx_no_crc  <= rd_word[`UEFC_CB_NOCRC]; // see RL20
								tx_no_pad  <= rd_word[`UEFC_CB_NOPAD]; // see RL20
								sum_running <= rd_word[`UEFC_CB_SUM] &
									cmd_a[`UEFC_CA_FIRST] & sum_offload_on; // see RL19
								tx_sum_start <= rd_word[`UEFC_CB_SUM] &
									cmd_a[`UEFC_CA_FIRST] & sum_offload_on; // see RL19
							end
						end
					end
				end
				// payload words with trimmed byte enables
				ST_DATA: begin
					if (tx_avail && can_out) begin
						tx_rd_ptr  <= tx_rd_ptr + {{`UEFC_TXAW{1'b0}}, 1'b1};
						tx_valid   <= 1'b1;
						tx_data    <= rd_word;
						tx_byte_en <= lanes; // see RL21 RL22
						first_word <= 1'b0;
						buf_left   <= buf_left - lane_n;
						frame_left <= frame_left - lane_n;
						tx_last    <= (frame_left == lane_n);  // see RL21
						if (buf_left == lane_n) begin
							tx_state <= ST_CMDA;
							if (frame_left == lane_n)
								sum_running <= 1'b0;
						end
					end
				end
				// out of step: flag holds until reset
				ST_HALT: begin
					tx_sync_error_flag <= 1'b1; // see RL25
				end
				default: tx_state <= ST_HALT;
			endcase
		end
	end

endmodule // uefc_fifo_ctrl

`default_nettype wire

// ==== uefc_chk_assertions.sv ====
// port checker for the frame fifo control block
`default_nettype none
module uefc_chk (
	// clock and reset
	input wire logic        pclk,
	input wire logic        presetn,
	// register bus
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pslverr,
	// receive status side
	input wire logic [31:0] rx_status_word,
	input wire logic        rx_status_valid,
	input wire logic        rx_frame_accept,
	input wire logic        rx_halted_pulse,
	// transmit side
	input wire logic        tx_valid,
	input wire logic        tx_ready,
	input wire logic [31:0] tx_data,
	input wire logic [3:0]  tx_byte_en,
	input wire logic        tx_last,
	input wire logic        tx_sum_start,
	input wire logic        tx_sync_error_flag
);
	timeunit 1ns;
	timeprecision 1ps;
	// one clock domain, checks paused in reset
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// short aliases for the status word and its strobe
	wire [31:0] sw = rx_status_word;
	wire        st = rx_status_valid;
	a_err_in_access: assert property (pslverr |-> psel && penable)
		else $error("slave error outside access");
	a_es_summary: assert property (st |-> sw[15] == |{sw[11], sw[7], sw[6], sw[1]})
		else $error("summary bit wrong");
	a_runt_mark: assert property (st && sw[29:16] < 14'd64 |-> sw[11])
		else $error("short frame not marked");
	a_long_mark: assert property (st && sw[29:16] > 14'd1518 |-> sw[7])
		else $error("long frame not marked");
	a_short_type: assert property (st && sw[29:16] < 14'd14 |-> !sw[5])
		else $error("type bit on tiny frame");
	a_drib_late: assert property (st && sw[6] |-> !sw[2])
		else $error("dribble with late collision");
	a_media_crc: assert property (st && sw[3] |-> sw[1])
		else $error("receive error without crc bit");
	a_accept_gate: assert property (rx_frame_accept != st |-> st && sw[11])
		else $error("acceptance wrong");
	a_halt_pulse: assert property (rx_halted_pulse |=> !rx_halted_pulse)
		else $error("halt event not a pulse");
	a_err_sticky: assert property (tx_sync_error_flag |=> tx_sync_error_flag)
		else $error("error flag dropped");
	a_tx_hold: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data)
		&& $stable(tx_byte_en) && $stable(tx_last)) else $error("tx word not held");
	a_be_nonzero: assert property (tx_valid |-> tx_byte_en != 4'h0)
		else $error("empty byte enables");
	a_sum_pulse: assert property (tx_sum_start |=> !tx_sum_start)
		else $error("sum start not a pulse");
endmodule // uefc_chk
bind uefc_fifo_ctrl uefc_chk i_uefc_chk (.*);
`default_nettype wire

// ==== uefc_mac_model.sv ====
// mac side model: frame source on receive, stalling sink on transmit
`default_nettype none
module uefc_mac_model (
	// clock
	input  wire logic        pclk,
	// receive pins toward the block
	output var  logic        rx_valid,
	output var  logic [7:0]  rx_byte,
	output var  logic        rx_end,
	output var  logic        rx_crc_bad,
	output var  logic        rx_media_err,
	output var  logic        rx_late_col,
	output var  logic [2:0]  rx_dribble_bits,
	output var  logic        rx_slow_mode,
	output var  logic        rx_filter_fail,
	// transmit side from the block
	input  wire logic        tx_valid,
	input  wire logic [31:0] tx_data,
	input  wire logic [3:0]  tx_byte_en,
	input  wire logic        tx_last,
	input  wire logic        tx_no_crc,
	input  wire logic        tx_no_pad,
	output var  logic        tx_ready
);
	timeunit 1ns;
	timeprecision 1ps;
	// accepted words: data, enables, last, no crc, no pad
	logic [38:0] got_q[$];
	// idle pins at time zero
	initial begin
		{rx_valid, rx_end, rx_media_err, tx_ready} = 4'h0;
		{rx_filter_fail, rx_slow_mode, rx_dribble_bits, rx_late_col, rx_crc_bad} = 7'h00;
		rx_byte = 8'h00;
	end
	// record taken words; ready drops at random
	always @(posedge pclk) begin
		if (tx_valid && tx_ready)
			got_q.push_back({tx_data, tx_byte_en, tx_last, tx_no_crc, tx_no_pad});
		tx_ready <= ($urandom % 3) != 0;
	end
	// one frame; receive error pulses mid-frame
	task automatic send(input int n, input logic [7:0] d0, input logic [15:0] t,
		input logic [6:0] lv, input logic me);
		logic [7:0] b;
		{rx_filter_fail, rx_slow_mode, rx_dribble_bits, rx_late_col, rx_crc_bad} <= lv;
		for (int i = 0; i < n; i++) begin
			@(posedge pclk);
			b = 8'($urandom);
			if (i < 6 && (d0 == 8'hFF || i == 0))
				b = d0;
			if (i == 12)
				b = t[15:8];
			if (i == 13)
				b = t[7:0];
			rx_valid <= 1'b1;
			rx_byte <= b;
			rx_media_err <= me && i == n / 2;
		end
		@(posedge pclk);
		rx_valid <= 1'b0;
		rx_byte <= ~b;
		rx_media_err <= 1'b0;
		rx_end <= 1'b1;
		@(posedge pclk);
		rx_end <= 1'b0;
	endtask
endmodule // uefc_mac_model
`default_nettype wire

// ==== uefc_fifo_ctrl_tb.sv ====
// self-checking bench for the frame fifo control block
`include "uefc_regs.vh"
`default_nettype none
module uefc_fifo_ctrl_tb;
	timeunit 1ns;
	timeprecision 1ps;
	// bus, receive and transmit signals
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rx_status_word, out_word, tx_data, rd_v;
	logic        rx_valid, rx_end, rx_crc_bad, rx_media_err, rx_late_col, rx_slow_mode;
	logic        rx_filter_fail, rx_halted_pulse, rx_frame_accept, rx_status_valid;
	logic [7:0]  rx_byte;
	logic [2:0]  rx_dribble_bits, b;
	logic        out_valid, out_commit, out_rewind, out_ready, tx_valid, tx_last;
	logic        tx_no_crc, tx_no_pad, tx_sum_start, tx_ready, tx_sync_error_flag, pb, on;
	logic [3:0]  tx_byte_en;
	logic [1:0]  o;
	logic [10:0] s;
	// bench counters and expected transmit words
	int          err_total, checks_done, sum_cnt, sum_exp, halt_cnt, hb;
	logic [38:0] exp_q[$];

	uefc_fifo_ctrl i_uefc_fifo_ctrl (.*);
	uefc_mac_model i_uefc_mac_model (.*);

	// 4 ns bus clock
	initial begin
		pclk = 1'b0;
		forever #2 pclk = ~pclk;
	end
	// count checksum starts and halt events
	always @(posedge pclk) begin
		sum_cnt <= sum_cnt + (tx_sum_start === 1'b1);
		halt_cnt <= halt_cnt + (rx_halted_pulse === 1'b1);
	end
	task automatic summarize();
		$display("checks %0d mismatches %0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task automatic cmp(input logic [38:0] g, input logic [38:0] e, input string m);
		checks_done++;
		if (g !== e) begin
			err_total++;
			$display("[ERR] %0t %s got %h exp %h", $time, m, g, e);
		end
	endtask
	task automatic tmo();
		err_total++;
		$display("[ERR] %0t wait ran out", $time);
		summarize();
	endtask
	// bounded wait on status strobe, halt event or error flag
	task automatic wait_on(input int w, input int lim);
		for (int k = 0; k < lim; k++) begin
			@(posedge pclk);
			if (w == 0 ? rx_status_valid === 1'b1 : w == 1 ? halt_cnt > hb
				: tx_sync_error_flag === 1'b1)
				return;
		end
		tmo();
	endtask
	// one bus transfer, then an idle cycle
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
		output logic er);
		int k;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		k = 0;
		do begin
			@(posedge pclk);
			k++;
		end while (pready !== 1'b1 && k < 50);
		rd_v = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (k >= 50)
			tmo();
		@(posedge pclk);
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		logic e;
		apb(1'b1, a, d, e);
		cmp(e, 1'b0, "write refused");
	endtask
	task automatic rd(input logic [11:0] a, input logic [31:0] x, input logic xe);
		logic e;
		apb(1'b0, a, 32'h0, e);
		cmp({rd_v, e}, {x, xe}, "read");
	endtask
	// expected receive status word
	function automatic logic [31:0] exp_st(input int n, input logic [7:0] d0,
		input logic [15:0] t, input logic [6:0] lv, input logic me);
		logic [31:0] x;
		x = 32'h0;
		x[30] = lv[6];
		x[29:16] = 14'(n);
		x[13] = d0 == 8'hFF;
		x[12] = n >= 14 && t <= 16'd1500;
		x[11] = n < 64;
		x[10] = d0[0];
		x[7] = n > 1518;
		x[6] = lv[1];
		x[5] = n >= 14 && t > 16'd1500;
		x[4] = n > 2048;
		x[3] = me;
		x[2] = !lv[1] && (lv[5] ? lv[4:2] >= 3'd3 : lv[4:2] == 3'd4);
		x[1] = lv[0] || me;
		x[15] = x[11] | x[7] | x[6] | x[1];
		return x;
	endfunction
	// one frame: status word and acceptance; multicast masked on broadcast
	task automatic rx(input int n, input logic [7:0] d0 = 8'h02,
		input logic [15:0] t = 16'h0800, input logic [6:0] lv = 7'h00, input logic me = 1'b0);
		logic [31:0] x, m;
		x = exp_st(n, d0, t, lv, me);
		m = (d0 == 8'hFF) ? 32'hFFFFFBFF : 32'hFFFFFFFF;
		i_uefc_mac_model.send(n, d0, t, lv, me);
		wait_on(0, 40);
		cmp(rx_status_word & m, x & m, "status");
		cmp(rx_frame_accept, !x[11] || pb, "accept");
	endtask
	// hand one word to the write side
	task automatic put(input logic [31:0] w);
		int k;
		out_valid <= 1'b1;
		out_word <= w;
		k = 0;
		do begin
			@(posedge pclk);
			k++;
		end while (out_ready !== 1'b1 && k < 300);
		if (k >= 300)
			tmo();
	endtask
	// byte enables of data word i of n
	function automatic logic [3:0] be_of(input int i, input int n, input int of, input int sz);
		be_of = 4'h0;
		for (int q = (i == 0 ? of : 0); q <= (i == n - 1 ? (of + sz - 1) % 4 : 3); q++)
			be_of[q] = 1'b1;
	endfunction
	// one buffer: word a, word b, payload, then commit
	task automatic put_buf(input logic [1:0] of, input logic fs, input logic ls,
		input logic [10:0] sz, input logic [31:0] cb);
		int n;
		logic [31:0] w;
		n = (of + sz + 3) / 4;
		put({14'h0, of, 2'b00, fs, ls, 1'b0, sz});
		put(cb);
		for (int i = 0; i < n; i++) begin
			w = $urandom;
			put(w);
			exp_q.push_back({w, be_of(i, n, of, sz), ls && i == n - 1, cb[13], cb[12]});
		end
		out_valid <= 1'b0;
		out_commit <= 1'b1;
		@(posedge pclk);
		out_commit <= 1'b0;
	endtask
	// compare enabled bytes of sent words
	task automatic txchk();
		logic [38:0] g, e;
		for (int k = 0; i_uefc_mac_model.got_q.size() < exp_q.size(); k++) begin
			if (k > 2000)
				tmo();
			@(posedge pclk);
		end
		repeat (4) @(posedge pclk);
		while (exp_q.size() > 0) begin
			e = exp_q.pop_front();
			g = i_uefc_mac_model.got_q.size() > 0 ? i_uefc_mac_model.got_q.pop_front() : '0;
			for (int q = 0; q < 4; q++)
				if (e[3 + q] !== 1'b1) begin
					e[7 + 8 * q +: 8] = 8'h00;
					g[7 + 8 * q +: 8] = 8'h00;
				end
			cmp(g, e, "tx word");
		end
		cmp(i_uefc_mac_model.got_q.size(), 0, "extra tx words");
		cmp(sum_cnt, sum_exp, "sum starts");
		cmp(tx_sync_error_flag, 1'b0, "tx error");
	endtask
	task automatic do_reset();
		presetn <= 1'b0;
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
	endtask
	// main sequence
	initial begin
		{presetn, psel, penable, pwrite, out_valid, out_commit, out_rewind, pb} = 8'h00;
		{paddr, pwdata, out_word} = 76'h0;
		{err_total, checks_done, sum_cnt, sum_exp, halt_cnt, hb} = '0;
		rd_v = $urandom(4);
		do_reset();
		rd(`UEFC_CTRL_ADDR, `UEFC_CTRL_RESET, 1'b0);
		rd(12'h010, 32'h0, 1'b1);
		wr(`UEFC_CTRL_ADDR, 32'h1);
		rx(40, 8'hFF);
		rx(80, 8'h01);
		rx(100, , 16'd1000);
		rx(10);
		rx(1600);
		rx(2100);
		rx(70, , , 7'h12);
		rx(70, , , 7'h10);
		rx(70, , , 7'h2C);
		rx(70, , , 7'h01);
		rx(70, , , , 1'b1);
		rx(70, , , 7'h40);
		for (int i = 0; i < 6; i++)
			rx(64 + $urandom % 240, 8'($urandom), 16'h0600 + 16'($urandom % 4096),
				7'($urandom) & 7'h41, 1'b0);
		hb = halt_cnt;
		wr(`UEFC_CTRL_ADDR, 32'h0);
		wait_on(1, 50);
		wr(`UEFC_CTRL_ADDR, 32'h2);
		rd(`UEFC_CTRL_ADDR, 32'h0, 1'b0);
		rd(`UEFC_STAT_ADDR, 32'h2, 1'b0);
		cmp(halt_cnt, hb + 1, "halt events");
		wr(`UEFC_CTRL_ADDR, 32'h5);
		pb = 1'b1;
		rx(30);
		for (int i = 0; i < 3; i++)
			put(32'hA5A50000 + i);
		out_valid <= 1'b0;
		out_rewind <= 1'b1;
		@(posedge pclk);
		out_rewind <= 1'b0;
		for (int i = 0; i < 6; i++) begin
			o = (i == 0) ? 2'd3 : 2'($urandom);
			s = (i == 0) ? 11'd1 : 11'(1 + $urandom % 40);
			b = 3'($urandom);
			on = 1'($urandom);
			wr(`UEFC_CTRL_ADDR, {28'h0, on, 3'b101});
			sum_exp += b[2] & on;
			put_buf(o, 1'b1, 1'b1, s, {17'h0, b, 1'b0, s});
			txchk();
		end
		wr(`UEFC_CTRL_ADDR, 32'h9);
		sum_exp++;
		put_buf(2'd1, 1'b1, 1'b0, 11'd7, {17'h0, 3'b100, 1'b0, 11'd16});
		put_buf(2'd2, 1'b0, 1'b1, 11'd9, {17'h0, 3'b000, 1'b0, 11'd16});
		txchk();
		put_buf(2'd0, 1'b1, 1'b1, 11'd8, {17'h0, 3'b000, 1'b0, 11'd20});
		wait_on(2, 300);
		repeat (20) @(posedge pclk);
		cmp(tx_sync_error_flag, 1'b1, "flag dropped");
		do_reset();
		exp_q.delete();
		i_uefc_mac_model.got_q.delete();
		cmp(tx_sync_error_flag, 1'b0, "flag after reset");
		put_buf(2'd0, 1'b1, 1'b0, 11'd8, {17'h0, 3'b000, 1'b0, 11'd16});
		put_buf(2'd0, 1'b0, 1'b1, 11'd8, {17'h0, 3'b010, 1'b0, 11'd16});
		wait_on(2, 300);
		summarize();
	end
endmodule // uefc_fifo_ctrl_tb
`default_nettype wire
